/* File: logic/fpr_duty_ramp.sv */
/*
  Duty ramp: moves the output duty toward a target by at most one step on
  each slot tick. Assumes tick and target come from the same clock domain.
*/
`timescale 1ns/100ps
module fpr_duty_ramp
(
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  // ramp control
  input  wire logic       i_tick,
  input  wire logic [5:0] i_step,
  input  wire logic [7:0] i_target,
  // ramped duty
  output logic      [7:0] o_duty
);
  import fpr_pkg::*;

  logic [8:0] up_gap;
  logic [8:0] down_gap;
  logic [8:0] step_w;
  logic [7:0] next_duty;

  // distance to target and clamped step toward it
  assign step_w   = {3'h0, i_step};
  assign up_gap   = {1'b0, i_target} - {1'b0, o_duty};
  assign down_gap = {1'b0, o_duty} - {1'b0, i_target};
  assign next_duty = (i_target > o_duty) ?
                       ((up_gap > step_w) ? 8'(o_duty + i_step) : i_target) : // RULE13
                     (i_target < o_duty) ?
                       ((down_gap > step_w) ? 8'(o_duty - i_step) : i_target) :
                     o_duty;

  // duty register, advances only on slot ticks
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      o_duty <= FPR_DUTY_RST;
    else if (i_tick)
      o_duty <= next_duty; // RULE10
  end

endmodule

/* File: logic/fpr_fan_rate_span.sv */
/*
  Fan drive rate, temperature span and acoustic ramp configuration for three
  fan channels, plus the ramped duty for the channel driven by remote 1.
  Assumes register writes and reads arrive from the serial register engine
  on the core clock, and that the lock and slot-mode bits come from other
  configuration registers in the same clock domain.
*/
//
// Behaviour
// [RULE1] three span and rate registers, one per channel
// [RULE2] span and rate registers reset to C4
// [RULE3] lock bit makes registers ignore writes
// [RULE4] low rate field ignored in high mode
// [RULE5] rate codes map 11.0 to 88.2 Hz
// [RULE6] bit 3 selects high or low rate
// [RULE7] bits 7..4 set automatic temperature span
// [RULE8] span codes map 2 to 80 degrees
// [RULE9] acoustic ramp register resets to zero
// [RULE10] ramp code caps remote 1 duty change rate
// [RULE11] ramp codes give increments 1 to 12; codes 6 and 7 here give 24 and 48
// [RULE12] per-channel slow bit divides ramp rate by four
// [RULE13] step toward target, never overshoot
`timescale 1ns/100ps
module fpr_fan_rate_span
#(
  parameter int SLOT_NORM_CYC = fpr_pkg::FPR_SLOT_NORM_CYC,
  parameter int SLOT_ALT_CYC  = fpr_pkg::FPR_SLOT_ALT_CYC
)
(
  // clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rstn,
  // register access
  input  wire fpr_pkg::fpr_reg_wr_t  i_reg_wr,
  input  wire logic [7:0]            i_rd_addr,
  output logic [7:0]                 o_rd_data,
  // lock and ramp mode bits from other configuration registers
  input  wire logic                  i_cfg_lock,
  input  wire logic                  i_slot_alt_mode,
  input  wire logic [2:0]            i_ramp_slow,
  // automatic control target for the remote 1 channel
  input  wire logic [7:0]            i_remote1_target,
  // per-channel configuration and decoded values
  output fpr_pkg::fpr_chan_cfg_t     o_fan_drive_channel [3],
  output logic [9:0]                 o_low_rate_dhz [3],
  output logic [13:0]                o_span_cdeg [3],
  // ramped remote 1 duty
  output logic [7:0]                 o_remote1_duty
);
  import fpr_pkg::*;

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  fpr_chan_cfg_t chan_cfg [FPR_CHANNELS];
  logic [7:0]    acoustic_ramp_ctrl_one;
  logic          wr_ok;
  logic          ramp_reg_hit;
  logic [2:0]    ramp_limit_code;
  logic [7:0]    chan_ofs [FPR_CHANNELS];
  logic [7:0]    next_rd_data;

  // writes pass only while unlocked
  // lock is sampled with the write strobe in the same cycle
  // a locked write is dropped with no indication
  assign wr_ok    = i_reg_wr.wr && !i_cfg_lock; // RULE3
  assign ramp_reg_hit = wr_ok && (i_reg_wr.addr == FPR_OFS_ACOUSTIC_RAMP_CTRL_ONE);
  assign ramp_limit_code = acoustic_ramp_ctrl_one[FPR_RAMP_LSB +: 3];

  // channel offsets
  // index 0 is remote 1, 1 is local, 2 is remote 2
  assign chan_ofs[0] = FPR_OFS_REMOTE1_SPAN_PWM1_RATE; // RULE1
  assign chan_ofs[1] = FPR_OFS_LOCAL_SPAN_PWM2_RATE;
  assign chan_ofs[2] = FPR_OFS_REMOTE2_SPAN_PWM3_RATE;

  // ----------------------------------------------------------------------
  // per-channel span and rate registers
  // ----------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < FPR_CHANNELS; ch++)
    begin : g_chan
      logic          hit;
      fpr_chan_cfg_t wcfg;
      logic [9:0]    next_rate;

      // write decode and field split
      // each channel compares against its own offset
      assign hit  = wr_ok && (i_reg_wr.addr == chan_ofs[ch]);
      assign wcfg.auto_temp_span  = i_reg_wr.wdata[FPR_SPAN_LSB +: 4]; // RULE7
      assign wcfg.hi_lo_rate_mode = i_reg_wr.wdata[FPR_MODE_BIT];      // RULE6
      assign wcfg.low_rate_select = i_reg_wr.wdata[FPR_RATE_LSB +: 3];
      // low rate applies only in low mode, zero in high mode
      // the stored rate code is kept while in high mode
      assign next_rate = chan_cfg[ch].hi_lo_rate_mode ? 10'h000 :     // RULE4
                         fpr_rate_dhz(chan_cfg[ch].low_rate_select);  // RULE5

      // span and rate register
      // reset value gives the default rate and span
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rstn)
          chan_cfg[ch] <= FPR_SPAN_RATE_RST; // RULE2
        else if (hit)
          chan_cfg[ch] <= wcfg;
      end

      // decoded outputs
      // values trail the register by one cycle
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rstn)
        begin
          o_fan_drive_channel[ch] <= FPR_SPAN_RATE_RST;
          o_low_rate_dhz[ch]      <= 10'h000;
          o_span_cdeg[ch]         <= 14'h0000;
        end
        else
        begin
          o_fan_drive_channel[ch] <= chan_cfg[ch];
          o_low_rate_dhz[ch]      <= next_rate;
          o_span_cdeg[ch]         <= fpr_span_cdeg(chan_cfg[ch].auto_temp_span); // RULE8
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // acoustic ramp register
  // ----------------------------------------------------------------------
  // only bits 2..0 act; upper bits read back as written
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      acoustic_ramp_ctrl_one <= FPR_ACOUSTIC_RST; // RULE9
    else if (ramp_reg_hit)
      acoustic_ramp_ctrl_one <= i_reg_wr.wdata;
  end

  // ----------------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------------
  // unmapped addresses read zero
  // read data trails the address by one cycle
  assign next_rd_data =
    (i_rd_addr == chan_ofs[0]) ? chan_cfg[0] :
    (i_rd_addr == chan_ofs[1]) ? chan_cfg[1] :
    (i_rd_addr == chan_ofs[2]) ? chan_cfg[2] :
    (i_rd_addr == FPR_OFS_ACOUSTIC_RAMP_CTRL_ONE) ? acoustic_ramp_ctrl_one :
    8'h00;

  // registered read data
  // reads have no side effects, so no strobe is needed
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      o_rd_data <= 8'h00;
    else
      o_rd_data <= next_rd_data;
  end

  // ----------------------------------------------------------------------
  // ramp time slots
  // ----------------------------------------------------------------------
  // last count of each slot length
  localparam logic [23:0] SLOT_NORM_LAST = 24'(SLOT_NORM_CYC - 1);
  localparam logic [23:0] SLOT_ALT_LAST  = 24'(SLOT_ALT_CYC - 1);

  logic [23:0] slot_cnt;
  logic [23:0] slot_last;
  logic        slot_end;
  logic [1:0]  slow_cnt;
  logic        slow_sel;
  logic        ramp_tick;
  logic [5:0]  ramp_step;

  // slot length from slot mode, quarter rate when slowed
  // end test uses >= so a shorter slot after a mode
  // change closes the running slot at once
  assign slot_last = i_slot_alt_mode ? SLOT_ALT_LAST : SLOT_NORM_LAST;
  assign slot_end  = (slot_cnt >= slot_last);
  assign slow_sel  = i_ramp_slow[FPR_RAMP_CHANNEL];
  assign ramp_tick = slot_end && (!slow_sel || (slow_cnt == FPR_SLOW_LAST)); // RULE12
  assign ramp_step = fpr_ramp_step(ramp_limit_code); // RULE11

  // slot counter
  // runs free from reset; a mode change applies to the running slot at once
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      slot_cnt <= 24'h000000;
    else if (slot_end)
      slot_cnt <= 24'h000000;
    else
      slot_cnt <= slot_cnt + 24'h000001;
  end

  // slot divider for the slowed ramp
  // not cleared when the slow bit flips, so the first
  // slowed tick may come up to three slots early
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rstn)
      slow_cnt <= 2'h0;
    else if (slot_end)
      slow_cnt <= slow_cnt + 2'h1;
  end

  // ----------------------------------------------------------------------
  // remote 1 duty ramp
  // ----------------------------------------------------------------------
  // only the remote 1 channel ramps; the others
  // take their duty without a rate limit
  fpr_duty_ramp u_ramp
  (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_tick     (ramp_tick),
    .i_step     (ramp_step),
    .i_target   (i_remote1_target),
    .o_duty     (o_remote1_duty)
  );

endmodule

/* File: logic/fpr_pkg.sv */
/*
  Package for the fan drive rate, temperature span and acoustic ramp block:
  register offsets, field positions, reset values, ramp timing and the
  decoding tables. Assumes a 50 MHz core clock.
*/
package fpr_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] FPR_OFS_REMOTE1_SPAN_PWM1_RATE = 8'h5F;
  localparam logic [7:0] FPR_OFS_LOCAL_SPAN_PWM2_RATE   = 8'h60;
  localparam logic [7:0] FPR_OFS_REMOTE2_SPAN_PWM3_RATE = 8'h61;
  localparam logic [7:0] FPR_OFS_ACOUSTIC_RAMP_CTRL_ONE = 8'h62;

  // ----------------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] FPR_SPAN_RATE_RST     = 8'hC4;
  localparam logic [7:0] FPR_ACOUSTIC_RST      = 8'h00;
  localparam logic [7:0] FPR_DUTY_RST          = 8'h00;
  localparam int         FPR_RATE_LSB          = 0;
  localparam int         FPR_MODE_BIT          = 3;
  localparam int         FPR_SPAN_LSB          = 4;
  localparam int         FPR_RAMP_LSB          = 0;
  localparam int         FPR_CHANNELS          = 3;
  localparam int         FPR_RAMP_CHANNEL      = 0;

  // ----------------------------------------------------------------------
  // ramp time slot: full 0..100 % ramp at step 1 over 256 duty steps
  // ----------------------------------------------------------------------
  localparam int         FPR_CLK_HZ            = 50_000_000;
  localparam int         FPR_SLOT_NORM_US      = 146_484;
  localparam int         FPR_SLOT_ALT_US       = 203_906;
  localparam int         FPR_SLOT_NORM_CYC     = FPR_SLOT_NORM_US * (FPR_CLK_HZ / 1_000_000);
  localparam int         FPR_SLOT_ALT_CYC      = FPR_SLOT_ALT_US * (FPR_CLK_HZ / 1_000_000);
  localparam logic [1:0] FPR_SLOW_LAST         = 2'h3;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] auto_temp_span;
    logic       hi_lo_rate_mode;
    logic [2:0] low_rate_select;
  } fpr_chan_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
  } fpr_reg_wr_t;

  // ----------------------------------------------------------------------
  // decoding tables
  // ----------------------------------------------------------------------
  // low rate code to tenths of a hertz
  function automatic logic [9:0] fpr_rate_dhz(input logic [2:0] code);
    case (code)
      3'h0:    fpr_rate_dhz = 10'h06E;
      3'h1:    fpr_rate_dhz = 10'h093;
      3'h2:    fpr_rate_dhz = 10'h0DD;
      3'h3:    fpr_rate_dhz = 10'h126;
      3'h4:    fpr_rate_dhz = 10'h161;
      3'h5:    fpr_rate_dhz = 10'h1B9;
      3'h6:    fpr_rate_dhz = 10'h24C;
      default: fpr_rate_dhz = 10'h372;
    endcase
  endfunction

  // span code to hundredths of a degree
  function automatic logic [13:0] fpr_span_cdeg(input logic [3:0] code);
    case (code)
      4'h0:    fpr_span_cdeg = 14'h00C8;
      4'h1:    fpr_span_cdeg = 14'h00FA;
      4'h2:    fpr_span_cdeg = 14'h014D;
      4'h3:    fpr_span_cdeg = 14'h0190;
      4'h4:    fpr_span_cdeg = 14'h01F4;
      4'h5:    fpr_span_cdeg = 14'h029B;
      4'h6:    fpr_span_cdeg = 14'h0320;
      4'h7:    fpr_span_cdeg = 14'h03E8;
      4'h8:    fpr_span_cdeg = 14'h0535;
      4'h9:    fpr_span_cdeg = 14'h0640;
      4'hA:    fpr_span_cdeg = 14'h07D0;
      4'hB:    fpr_span_cdeg = 14'h0A6B;
      4'hC:    fpr_span_cdeg = 14'h0C80;
      4'hD:    fpr_span_cdeg = 14'h0FA0;
      4'hE:    fpr_span_cdeg = 14'h14D5;
      default: fpr_span_cdeg = 14'h1F40;
    endcase
  endfunction

  // ramp code to duty increment per time slot
  function automatic logic [5:0] fpr_ramp_step(input logic [2:0] code);
    case (code)
      3'h0:    fpr_ramp_step = 6'h01;
      3'h1:    fpr_ramp_step = 6'h02;
      3'h2:    fpr_ramp_step = 6'h03;
      3'h3:    fpr_ramp_step = 6'h04;
      3'h4:    fpr_ramp_step = 6'h08;
      3'h5:    fpr_ramp_step = 6'h0C;
      3'h6:    fpr_ramp_step = 6'h18;
      default: fpr_ramp_step = 6'h30;
    endcase
  endfunction

endpackage

/* File: testbench/fpr_fan_model.sv */
/*
  Fan model on the remote 1 drive: follows the ramped duty, counts duty
  moves and the cycles between the last two moves.
  Assumes the duty is driven on the core clock.
*/
`timescale 1ns/100ps
module fpr_fan_model
(
  // clock
  input  wire logic       i_core_clk,
  // drive from the block
  input  wire logic [7:0] i_duty,
  // observation
  output int              o_gap,
  output int              o_moves
);
  logic [7:0] speed;
  int         cnt;

  // fan speed follows duty; measure spacing of duty moves
  always_ff @(posedge i_core_clk)
  begin
    speed <= i_duty;
    if (i_duty != speed)
    begin
      o_gap   <= cnt + 1;
      cnt     <= 0;
      o_moves <= o_moves + 1;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

/* File: testbench/fpr_fan_rate_span_sva.sv */
/*
  Checker for the span, rate and ramp block.
  Assumes it is bound to the block and sees only its ports.
*/
`timescale 1ns/100ps
module fpr_fan_rate_span_sva
#(
  parameter int SLOT_NORM_CYC = 8
)
(
  input wire logic                   i_core_clk,
  input wire logic                   i_rstn,
  input wire fpr_pkg::fpr_reg_wr_t   i_reg_wr,
  input wire logic [7:0]             i_rd_addr,
  input wire logic [7:0]             o_rd_data,
  input wire logic                   i_cfg_lock,
  input wire logic                   i_slot_alt_mode,
  input wire fpr_pkg::fpr_chan_cfg_t o_fan_drive_channel [3],
  input wire logic [9:0]             o_low_rate_dhz [3],
  input wire logic [13:0]            o_span_cdeg [3],
  input wire logic [7:0]             i_remote1_target,
  input wire logic [7:0]             o_remote1_duty
);
  import fpr_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  wire acc_w = i_reg_wr.wr && !i_cfg_lock;
  wire a5f   = acc_w && i_reg_wr.addr == FPR_OFS_REMOTE1_SPAN_PWM1_RATE;
  wire a62   = acc_w && i_reg_wr.addr == FPR_OFS_ACOUSTIC_RAMP_CTRL_ONE;
  int  gap;

  // cycles since the last duty move; parked high in the long slot mode
  always_ff @(posedge i_core_clk)
    if (!i_rstn || $changed(o_remote1_duty))
      gap <= 0;
    else if (i_slot_alt_mode)
      gap <= SLOT_NORM_CYC;
    else
      gap <= gap + 1;

  a_wr_to_cfg: assert property (a5f |-> ##2
    o_fan_drive_channel[0] == $past(i_reg_wr.wdata, 2)) else $error("cfg0 missed write");
  a_lock_freeze: assert property (i_cfg_lock && $past(i_cfg_lock) |=>
    $stable(o_fan_drive_channel[0])) else $error("cfg0 moved while locked");
  a_high_rate_zero: assert property (o_fan_drive_channel[2].hi_lo_rate_mode |->
    o_low_rate_dhz[2] == 10'h000) else $error("rate shown in high mode");
  a_rate_top: assert property (!o_fan_drive_channel[1].hi_lo_rate_mode &&
    o_fan_drive_channel[1].low_rate_select == 3'h7 |-> o_low_rate_dhz[1] == 10'h372)
    else $error("rate code 7 wrong");
  a_span_top: assert property (o_fan_drive_channel[1].auto_temp_span == 4'hF |->
    o_span_cdeg[1] == 14'h1F40) else $error("span code F wrong");
  a_unmapped_rd: assert property ($past(i_rd_addr) > 8'h62 || $past(i_rd_addr) < 8'h5F
    |-> o_rd_data == 8'h00) else $error("unmapped read not zero");
  a_rd_ramp_reg: assert property (a62 ##1 i_rd_addr == 8'h62 |=>
    o_rd_data == $past(i_reg_wr.wdata, 2)) else $error("ramp reg readback");
  a_no_overshoot: assert property ($changed(o_remote1_duty) &&
    $past(o_remote1_duty) < $past(i_remote1_target) |-> o_remote1_duty > $past(o_remote1_duty)
    && o_remote1_duty <= $past(i_remote1_target)) else $error("duty overshoot");
  a_slot_gap: assert property ($changed(o_remote1_duty) && !i_slot_alt_mode |->
    gap >= SLOT_NORM_CYC - 1) else $error("duty moved within slot");
endmodule

bind fpr_fan_rate_span fpr_fan_rate_span_sva #(.SLOT_NORM_CYC(SLOT_NORM_CYC)) u_sva (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr), .i_rd_addr(i_rd_addr),
  .o_rd_data(o_rd_data), .i_cfg_lock(i_cfg_lock), .i_slot_alt_mode(i_slot_alt_mode),
  .o_fan_drive_channel(o_fan_drive_channel), .o_low_rate_dhz(o_low_rate_dhz),
  .o_span_cdeg(o_span_cdeg), .i_remote1_target(i_remote1_target),
  .o_remote1_duty(o_remote1_duty));

/* File: testbench/fpr_fan_rate_span_tb.sv */
/*
  Self-checking bench for the span, rate and ramp block.
  Assumes short slot parameters and the fan model on the ramped duty.
*/
`timescale 1ns/100ps
module fpr_fan_rate_span_tb;
  import fpr_pkg::*;
  logic i_core_clk, i_rstn, i_cfg_lock, i_slot_alt_mode;
  logic [7:0] i_rd_addr, o_rd_data, i_remote1_target, o_remote1_duty, p;
  logic [2:0] i_ramp_slow;
  fpr_reg_wr_t i_reg_wr;
  fpr_chan_cfg_t o_fan_drive_channel [3];
  logic [9:0] o_low_rate_dhz [3];
  logic [13:0] o_span_cdeg [3];
  int n_errors, num_checks, cyc, gap, moves;
  int dhz_tab [8] = '{110, 147, 221, 294, 353, 441, 588, 882};
  int cdeg_tab [16] = '{200, 250, 333, 400, 500, 667, 800, 1000, 1333, 1600, 2000, 2667,
    3200, 4000, 5333, 8000};
  int step_tab [6] = '{1, 2, 3, 4, 8, 12};

  fpr_fan_rate_span #(.SLOT_NORM_CYC(8), .SLOT_ALT_CYC(12)) u_fpr_fan_rate_span (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr), .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data), .i_cfg_lock(i_cfg_lock), .i_slot_alt_mode(i_slot_alt_mode),
    .i_ramp_slow(i_ramp_slow), .i_remote1_target(i_remote1_target),
    .o_fan_drive_channel(o_fan_drive_channel), .o_low_rate_dhz(o_low_rate_dhz),
    .o_span_cdeg(o_span_cdeg), .o_remote1_duty(o_remote1_duty));
  fpr_fan_model u_fpr_fan_model (.i_core_clk(i_core_clk), .i_duty(o_remote1_duty),
    .o_gap(gap), .o_moves(moves));

  // clock and hang guard
  always #10 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      report_and_stop;
    end
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task check(input string nm, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk) #1 i_reg_wr = '{a, d, 1'b1};
    @(posedge i_core_clk) #1 i_reg_wr.wr = 1'b0;
    @(posedge i_core_clk) #1;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_core_clk) #1 i_rd_addr = a;
    repeat (2) @(posedge i_core_clk);
    #1 check("rd_data", o_rd_data, e);
  endtask

  // wait for the next duty move seen by the fan
  task wmove;
    int m;
    m = moves;
    while (moves == m) @(posedge i_core_clk);
    #1;
  endtask

  task t_reset;
    for (int a = 0; a < 4; a++) rd(8'(8'h5F + a), a == 3 ? 8'h00 : 8'hC4);
    check("dhz0", o_low_rate_dhz[0], 16'h0161);
    check("cdeg0", o_span_cdeg[0], 16'h0C80);
    $display("t_reset done");
  endtask

  task t_codes;
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h60, {i[3:0], 1'b0, i[2:0]});
      check("cfg1", o_fan_drive_channel[1], {i[3:0], 1'b0, i[2:0]});
      check("cdeg1", o_span_cdeg[1], 16'(cdeg_tab[i]));
      check("dhz1", o_low_rate_dhz[1], 16'(dhz_tab[i % 8]));
    end
    $display("t_codes done");
  endtask

  task t_hf;
    wr(8'h61, 8'h3D);
    check("dhz2 high", o_low_rate_dhz[2], 16'h0000);
    wr(8'h61, 8'h35);
    check("cfg2", o_fan_drive_channel[2], 16'h0035);
    check("dhz2 low", o_low_rate_dhz[2], 16'h01B9);
    $display("t_hf done");
  endtask

  task t_lock;
    @(posedge i_core_clk) #1 i_cfg_lock = 1'b1;
    wr(8'h5F, 8'hA7);
    wr(8'h62, 8'h05);
    rd(8'h5F, 8'hC4);
    rd(8'h62, 8'h00);
    @(posedge i_core_clk) #1 i_cfg_lock = 1'b0;
    wr(8'h5F, 8'hA7);
    check("cfg0", o_fan_drive_channel[0], 16'h00A7);
    check("dhz0 wr", o_low_rate_dhz[0], 16'(dhz_tab[7]));
    check("cdeg0 wr", o_span_cdeg[0], 16'(cdeg_tab[10]));
    wr(8'h63, 8'h55);
    rd(8'h63, 8'h00);
    $display("t_lock done");
  endtask

  task t_ramp;
    i_remote1_target = 8'hF0;
    i_rd_addr = 8'h62;
    for (int c = 0; c < 6; c++)
    begin
      wr(8'h62, 8'(c));
      check("ramp rd", o_rd_data, 16'(c));
      wmove;
      p = o_remote1_duty;
      wmove;
      check("duty step", o_remote1_duty, 16'(p + step_tab[c]));
    end
    wmove;
    p = o_remote1_duty;
    i_remote1_target = p + 8'h05;
    wmove;
    check("duty up", o_remote1_duty, 16'(p + 8'h05));
    i_remote1_target = p;
    wmove;
    check("duty down", o_remote1_duty, 16'(p));
    i_remote1_target = 8'hFF;
    i_ramp_slow = 3'h1;
    wmove;
    wmove;
    check("slow gap", 16'(gap), 16'h0020);
    i_ramp_slow = 3'h0;
    i_slot_alt_mode = 1'b1;
    wmove;
    wmove;
    check("alt gap", 16'(gap), 16'h000C);
    i_slot_alt_mode = 1'b0;
    $display("t_ramp done");
  endtask

  initial
  begin
    i_core_clk = 1'b0;
    i_rstn = 1'b0;
    i_cfg_lock = 1'b0;
    i_slot_alt_mode = 1'b0;
    i_ramp_slow = 3'h0;
    i_rd_addr = 8'h00;
    i_remote1_target = 8'h00;
    i_reg_wr = '{8'h00, 8'h00, 1'b0};
    repeat (16) @(posedge i_core_clk);
    #1 i_rstn = 1'b1;
    t_reset;
    t_codes;
    t_hf;
    t_lock;
    t_ramp;
    report_and_stop;
  end
endmodule
